// file: logic/srpc_refresh_power.v
// What this block does
// RULE1 - Deep select with refresh enable or mode set enters deep power-down.
// RULE2 - Low-frequency mode moves commands and read capture to falling edge.
// RULE3 - Refresh happens only while refresh enable is one.
// RULE4 - Mode one enters self-refresh; zero runs timer-paced auto-refresh.
// RULE5 - Sleep select drives clock enable low after each memory access.
// RULE6 - Open bank select picks plain commands, else auto-precharge commands.
// RULE7 - Software uses open bank only for area 3 at 16 bits.
// RULE8 - Row width code: 00=11, 01=12, 10=13 bits; 11 prohibited.
// RULE9 - Column width code: 00=8, 01=9, 10=10 bits; 11 prohibited.
// RULE10 - Timer register writes need the key in the upper half.
// RULE11 - Timer registers clear to zero on power-on reset only.
// RULE12 - Prescaler phase is realigned only by power-on reset.
// RULE13 - Match sets flag; cleared by zero write after reading it set.
// RULE14 - Interrupt enable gives request held until flag is cleared.
// RULE15 - Clock select 000 stops; others divide by 4 up to 4096.
// RULE16 - Burst count codes give 1, 2, 4, 6 or 8 refresh cycles.
// RULE17 - Counter is 8-bit, clears on match and wraps after 255.
// RULE18 - Match posts pending request; unserved one at next match dropped.
// RULE19 - Clearing the flag leaves the pending refresh request alone.
// RULE20 - Refresh request while bus released asserts the bus request output.
// RULE21 - Software leaves bus release extension alone while transfers run.
// RULE22 - Reserved bits read zero; software writes zero.
// RULE23 - Control register clears to zero on power-on reset only.
// RULE24 - Unkeyed write leaves the protected register unchanged.
`timescale 1ns/100ps
`include "srpc_defines.vh"

module srpc_refresh_power #(
  parameter REF_CYCLES = 8
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // AXI4-Lite write
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Access engine side
  input wire access_done,
  input wire bus_released,
  output reg refresh_busy,
  output reg refresh_bus_request_out,
  output reg match_irq,
  output reg open_bank_select,
  output reg falling_edge_mode,
  output reg [3:0] row_bits,
  output reg [3:0] col_bits,
  // Memory command pins
  output reg [3:0] mem_cmd,
  output reg mem_cke
);

  localparam ST_IDLE = 3'h0;
  localparam ST_PALL = 3'h1;
  localparam ST_REF = 3'h2;
  localparam ST_GAP = 3'h3;
  localparam ST_SELF = 3'h4;
  localparam ST_DEEP = 3'h5;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [11:0] div_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h1: div_mask = 12'h003;
        3'h2: div_mask = 12'h00f;
        3'h3: div_mask = 12'h03f;
        3'h4: div_mask = 12'h0ff;
        3'h5: div_mask = 12'h3ff;
        3'h6: div_mask = 12'h7ff;
        3'h7: div_mask = 12'hfff;
        default: div_mask = 12'h000;
      endcase
    end
  endfunction

  function [3:0] burst_len;
    input [2:0] code;
    begin
      case (code)
        3'h0: burst_len = 4'h1;
        3'h1: burst_len = 4'h2;
        3'h2: burst_len = 4'h4;
        3'h3: burst_len = 4'h6;
        default: burst_len = 4'h8;
      endcase
    end
  endfunction

  function keyed;
    input [31:0] d;
    begin
      keyed = (d[31:16] == `SRPC_KEY);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [31:0] sdram_control;
  reg match_flag;
  reg match_irq_enable;
  reg [2:0] prescale_select;
  reg [2:0] refresh_burst_count;
  reg [7:0] refresh_tick_counter;
  reg [7:0] refresh_interval_constant;
  reg [11:0] prescaler;
  reg flag_seen;
  reg pending;
  reg [2:0] state;
  reg [3:0] burst_left;
  reg [7:0] gap_cnt;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg aw_have;
  reg w_have;

  wire refresh_enable = sdram_control[`SRPC_SD_RFEN];
  wire self_vs_auto_refresh_select = sdram_control[`SRPC_SD_RSEL];
  wire deep_select = sdram_control[`SRPC_SD_DEEP];
  wire idle_sleep_after_access = sdram_control[`SRPC_SD_PSLEEP];
  wire [1:0] area3_row_width =
    sdram_control[`SRPC_SD_ROW_HI:`SRPC_SD_ROW_LO];
  wire [1:0] area3_column_width =
    sdram_control[`SRPC_SD_COL_HI:`SRPC_SD_COL_LO];

  // ----------------------------------------
  // Bus write channel
  // ----------------------------------------
  reg [3:0] s_axi_wstrb_q;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire [31:0] strb_mask = {{8{s_axi_wstrb_q[3]}}, {8{s_axi_wstrb_q[2]}},
                           {8{s_axi_wstrb_q[1]}}, {8{s_axi_wstrb_q[0]}}};
  wire wr_ctl = do_write && aw_addr == `SRPC_ADDR_SDCTL;
  wire wr_ts = do_write && aw_addr == `SRPC_ADDR_RTCS &&
               keyed(w_data); // RULE10
  wire wr_cnt = do_write && aw_addr == `SRPC_ADDR_REFRESH_TICK_COUNTER &&
                keyed(w_data); // RULE10
  wire wr_con = do_write && aw_addr == `SRPC_ADDR_RTCON &&
                keyed(w_data); // RULE10
  wire known_w = aw_addr == `SRPC_ADDR_SDCTL || aw_addr == `SRPC_ADDR_RTCS ||
                 aw_addr == `SRPC_ADDR_REFRESH_TICK_COUNTER || aw_addr == `SRPC_ADDR_RTCON;

  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRPC_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      s_axi_wstrb_q <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_w ? `SRPC_RESP_OKAY : `SRPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Bus read channel
  // ----------------------------------------
  wire [31:0] ts_word = {24'h000000, match_flag, match_irq_enable,
                         prescale_select, refresh_burst_count}; // RULE22
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_ts = rd_take && s_axi_araddr == `SRPC_ADDR_RTCS;

  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SRPC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SRPC_RESP_OKAY;
        case (s_axi_araddr)
          `SRPC_ADDR_SDCTL: s_axi_rdata <= sdram_control;
          `SRPC_ADDR_RTCS: s_axi_rdata <= ts_word;
          `SRPC_ADDR_REFRESH_TICK_COUNTER: s_axi_rdata <= {24'h000000, refresh_tick_counter};
          `SRPC_ADDR_RTCON:
            s_axi_rdata <= {24'h000000, refresh_interval_constant};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SRPC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control and timer registers
  // ----------------------------------------
  wire tick = (prescale_select != 3'h0) &&
              ((prescaler & div_mask(prescale_select)) ==
               div_mask(prescale_select)); // RULE15
  wire match = tick && refresh_tick_counter == refresh_interval_constant;
  wire flag_clear = wr_ts && !w_data[`SRPC_TS_FLAG] && flag_seen &&
                    s_axi_wstrb_q[0];

  always @(posedge clock) begin
    if (sys_rst) begin
      sdram_control <= `SRPC_RESET_VAL; // RULE23
      match_flag <= 1'b0; // RULE11
      match_irq_enable <= 1'b0;
      prescale_select <= 3'h0;
      refresh_burst_count <= 3'h0;
      refresh_tick_counter <= 8'h00;
      refresh_interval_constant <= 8'h00;
      prescaler <= 12'h000; // RULE12
      flag_seen <= 1'b0;
    end else begin
      prescaler <= prescaler + 12'h001; // RULE12
      if (wr_ctl)
        sdram_control <= (sdram_control & ~(`SRPC_SD_WMASK & strb_mask)) |
                         (w_data & `SRPC_SD_WMASK & strb_mask); // RULE22
      if (wr_ts && s_axi_wstrb_q[0]) begin // RULE24
        match_irq_enable <= w_data[`SRPC_TS_IEN];
        prescale_select <= w_data[`SRPC_TS_CKS_HI:`SRPC_TS_CKS_LO];
        refresh_burst_count <= w_data[`SRPC_TS_RRC_HI:`SRPC_TS_RRC_LO];
      end
      if (rd_ts)
        flag_seen <= match_flag; // RULE13
      else if (flag_clear)
        flag_seen <= 1'b0;
      if (match)
        match_flag <= 1'b1; // RULE13
      else if (flag_clear)
        match_flag <= 1'b0; // RULE13
      if (wr_cnt && s_axi_wstrb_q[0])
        refresh_tick_counter <= w_data[7:0]; // RULE24
      else if (match)
        refresh_tick_counter <= 8'h00; // RULE17
      else if (tick)
        refresh_tick_counter <= refresh_tick_counter + 8'h01; // RULE17
      if (wr_con && s_axi_wstrb_q[0])
        refresh_interval_constant <= w_data[7:0]; // RULE24
    end
  end

  // ----------------------------------------
  // Refresh sequencer
  // ----------------------------------------
  // Deep select turns either refresh bit into deep power-down entry
  wire want_self = deep_select ?
                   (refresh_enable || self_vs_auto_refresh_select) :
                   (refresh_enable && self_vs_auto_refresh_select); // RULE1

  always @(posedge clock) begin
    if (sys_rst) begin
      pending <= 1'b0;
      state <= ST_IDLE;
      burst_left <= 4'h0;
      gap_cnt <= 8'h00;
      mem_cmd <= `SRPC_CMD_NOP;
      mem_cke <= 1'b1;
    end else begin
      mem_cmd <= `SRPC_CMD_NOP;
      // Request only set by match; flag clear never touches it
      if (match && refresh_enable && !want_self)
        pending <= 1'b1; // RULE18 RULE19
      if (!mem_cke && access_done == 1'b0 && state == ST_IDLE &&
          !idle_sleep_after_access)
        mem_cke <= 1'b1;
      if (access_done)
        mem_cke <= !idle_sleep_after_access; // RULE5
      case (state)
        ST_IDLE: begin
          if (want_self) begin // RULE4
            mem_cke <= 1'b1;
            mem_cmd <= `SRPC_CMD_PALL;
            state <= deep_select ? ST_DEEP : ST_SELF; // RULE1
          end else if (pending && refresh_enable &&
                       !bus_released) begin // RULE3
            mem_cke <= 1'b1;
            mem_cmd <= `SRPC_CMD_PALL;
            burst_left <= burst_len(refresh_burst_count); // RULE16
            state <= ST_REF;
            if (!(match && refresh_enable))
              pending <= 1'b0;
          end
        end
        ST_REF: begin
          mem_cmd <= `SRPC_CMD_REF;
          burst_left <= burst_left - 4'h1;
          gap_cnt <= REF_CYCLES[7:0];
          state <= ST_GAP;
        end
        ST_GAP: begin
          if (gap_cnt != 8'h00)
            gap_cnt <= gap_cnt - 8'h01;
          else if (burst_left != 4'h0)
            state <= ST_REF; // RULE16
          else
            state <= ST_IDLE;
        end
        ST_SELF: begin
          if (!want_self) begin
            mem_cke <= 1'b1;
            state <= ST_IDLE;
          end else begin
            // Entry command only on the cycle clock enable falls
            if (mem_cke)
              mem_cmd <= `SRPC_CMD_REF; // RULE4
            mem_cke <= 1'b0;
          end
        end
        ST_DEEP: begin
          if (!want_self) begin
            mem_cke <= 1'b1;
            state <= ST_IDLE;
          end else begin
            if (mem_cke)
              mem_cmd <= `SRPC_CMD_DPD; // RULE1
            mem_cke <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status outputs to the access engine
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      refresh_busy <= 1'b0;
      refresh_bus_request_out <= 1'b0;
      match_irq <= 1'b0;
      open_bank_select <= 1'b0;
      falling_edge_mode <= 1'b0;
      row_bits <= 4'hb;
      col_bits <= 4'h8;
    end else begin
      refresh_busy <= state != ST_IDLE;
      refresh_bus_request_out <= pending && refresh_enable &&
                                 bus_released; // RULE20
      match_irq <= match_flag && match_irq_enable; // RULE14
      open_bank_select <= sdram_control[`SRPC_SD_OBANK]; // RULE6
      falling_edge_mode <= sdram_control[`SRPC_SD_SLOWCK]; // RULE2
      row_bits <= 4'hb + {2'b00, area3_row_width}; // RULE8
      col_bits <= 4'h8 + {2'b00, area3_column_width}; // RULE9
    end
  end

endmodule // srpc_refresh_power

// file: logic/srpc_defines.vh
`ifndef SRPC_DEFINES_VH
`define SRPC_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SRPC_ADDR_SDCTL 4'h0
`define SRPC_ADDR_RTCS 4'h4
`define SRPC_ADDR_REFRESH_TICK_COUNTER 4'h8
`define SRPC_ADDR_RTCON 4'hc

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SRPC_SD_DEEP 13
`define SRPC_SD_SLOWCK 12
`define SRPC_SD_RFEN 11
`define SRPC_SD_RSEL 10
`define SRPC_SD_PSLEEP 9
`define SRPC_SD_OBANK 8
`define SRPC_SD_ROW_HI 4
`define SRPC_SD_ROW_LO 3
`define SRPC_SD_COL_HI 1
`define SRPC_SD_COL_LO 0
`define SRPC_SD_WMASK 32'h00003f1b

// ----------------------------------------
// Timer status fields and protection key
// ----------------------------------------
`define SRPC_TS_FLAG 7
`define SRPC_TS_IEN 6
`define SRPC_TS_CKS_HI 5
`define SRPC_TS_CKS_LO 3
`define SRPC_TS_RRC_HI 2
`define SRPC_TS_RRC_LO 0
`define SRPC_KEY 16'ha55a
`define SRPC_RESET_VAL 32'h00000000

// ----------------------------------------
// Memory commands {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SRPC_CMD_NOP 4'h7
`define SRPC_CMD_REF 4'h1
`define SRPC_CMD_PALL 4'h2
`define SRPC_CMD_DPD 4'h6

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define SRPC_RESP_OKAY 2'h0
`define SRPC_RESP_SLVERR 2'h2

`endif

// file: bench/srpc_refresh_power_props.sv
`timescale 1ns/100ps
`include "srpc_defines.vh"
module srpc_refresh_power_props (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Read channel
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  // Write response, engine and memory side
  input wire s_axi_bvalid,
  input wire bus_released,
  input wire refresh_bus_request_out,
  input wire match_irq,
  input wire [3:0] row_bits,
  input wire [3:0] col_bits,
  input wire [3:0] mem_cmd,
  input wire mem_cke
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_reset_outputs: assert property (disable iff (1'b0)
    $past(sys_rst) |-> mem_cmd == `SRPC_CMD_NOP && mem_cke &&
      row_bits == 4'hb && col_bits == 4'h8 && !match_irq)
    else $error("outputs not at reset values");
  a_deep_cke_low: assert property (
    mem_cmd == `SRPC_CMD_DPD |-> ##[0:1] !mem_cke)
    else $error("deep entry without clock enable low");
  a_row_width: assert property (
    row_bits >= 4'hb && row_bits <= 4'he)
    else $error("row width out of range");
  a_col_width: assert property (
    col_bits >= 4'h8 && col_bits <= 4'hb)
    else $error("column width out of range");
  a_irq_clear_cause: assert property (
    $fell(match_irq) |-> $past(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  a_busreq_released: assert property (
    refresh_bus_request_out |->
      $past(bus_released) || $past(bus_released, 2))
    else $error("bus request while bus not released");
  a_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
    else $error("reserved read bits not zero");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
      ($past(s_axi_araddr[1:0]) == 2'h0 ||
       s_axi_rresp == `SRPC_RESP_SLVERR))
    else $error("read answer late or wrong");
endmodule // srpc_refresh_power_props

bind srpc_refresh_power srpc_refresh_power_props i_props (
  .clock, .sys_rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid,
  .bus_released, .refresh_bus_request_out, .match_irq, .row_bits,
  .col_bits, .mem_cmd, .mem_cke
);

// file: bench/srpc_sdram_model.sv
`timescale 1ns/100ps
`include "srpc_defines.vh"
module srpc_sdram_model (
  // Memory pins
  input wire clock,
  input wire [3:0] mem_cmd,
  input wire mem_cke,
  // Seen by the bench
  output integer refs,
  output logic [3:0] last_cmd
);
  initial begin
    refs = 0;
    last_cmd = `SRPC_CMD_NOP;
  end
  // Auto refresh counted only with clock enable high
  always @(posedge clock) begin
    if (mem_cmd != `SRPC_CMD_NOP)
      last_cmd <= mem_cmd;
    if (mem_cmd == `SRPC_CMD_REF && mem_cke)
      refs <= refs + 1;
  end
endmodule // srpc_sdram_model

// file: bench/srpc_refresh_power_test.sv
`timescale 1ns/100ps
`include "srpc_defines.vh"
module srpc_refresh_power_test;
  logic clock, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, access_done, bus_released;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d, q;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, refresh_busy, refresh_bus_request_out, match_irq;
  logic open_bank_select, falling_edge_mode, mem_cke;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] row_bits, col_bits, mem_cmd, last_cmd;
  integer refs, base, checks, n_mismatch, cycles, i;
  localparam logic [31:0] KEY = {`SRPC_KEY, 16'h0};
  localparam logic [3:0] A_CTL = `SRPC_ADDR_SDCTL;
  localparam logic [3:0] A_STS = `SRPC_ADDR_RTCS;
  localparam logic [3:0] A_CNT = `SRPC_ADDR_REFRESH_TICK_COUNTER;
  localparam logic [3:0] A_CON = `SRPC_ADDR_RTCON;
  localparam logic [1:0] OK = `SRPC_RESP_OKAY;

  srpc_refresh_power #(.REF_CYCLES(1)) i_dut (
    .clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .access_done, .bus_released,
    .refresh_busy, .refresh_bus_request_out, .match_irq,
    .open_bank_select, .falling_edge_mode, .row_bits, .col_bits,
    .mem_cmd, .mem_cke
  );
  srpc_sdram_model i_mem (.clock, .mem_cmd, .mem_cke, .refs, .last_cmd);

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function integer burst(input integer c);
    return c == 0 ? 1 : 2 * c;
  endfunction

  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task check_word(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: word %h, want %h", $time, g, e);
    end
  endtask
  task check_bit(input logic g, input logic e);
    checks = checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: bit %b, want %b", $time, g, e);
    end
  endtask
  task axi_write(input logic [3:0] a, input logic [31:0] v,
      input logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check_word({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task axi_read(input logic [3:0] a, output logic [31:0] v,
      input logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    check_word({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task wait_irq;
    @(posedge clock);
    while (match_irq !== 1'b1) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, access_done, bus_released} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    sys_rst = 1'b1;
    seed = 32'h84dd45c3;
    {checks, n_mismatch, cycles} = 96'h0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (i = 0; i < 16; i = i + 4) begin
      axi_read(i[3:0], q, OK);
      check_word(q, `SRPC_RESET_VAL);
    end
    axi_write(4'h2, 32'h1, `SRPC_RESP_SLVERR);
    axi_read(4'h2, q, `SRPC_RESP_SLVERR);
    check_word(q, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      d = i == 0 ? 32'h1112 : rnd() & 32'h131b;
      if (d[4:3] == 2'h3) d[4] = 1'b0;
      if (d[1:0] == 2'h3) d[1] = 1'b0;
      axi_write(A_CTL, d, OK);
      axi_read(A_CTL, q, OK);
      check_word(q, d);
      check_bit(falling_edge_mode, d[12]);
      check_bit(open_bank_select, d[8]);
      check_word({28'h0, row_bits}, 32'hb + d[4:3]);
      check_word({28'h0, col_bits}, 32'h8 + d[1:0]);
    end
    axi_write(A_CTL, 32'h0, OK);
    axi_write(A_CNT, 32'h55, OK);
    axi_read(A_CNT, q, OK);
    check_word(q, 32'h0);
    axi_write(A_CNT, KEY | 32'h55, OK);
    repeat (40) @(posedge clock);
    axi_read(A_CNT, q, OK);
    check_word(q, 32'h55);
    axi_write(A_CON, KEY | 32'h40, OK);
    axi_write(A_CTL, 32'h800, OK);
    d = 32'h0;
    for (i = 0; i < 6; i = i + 1) begin
      if (i == 5) axi_write(A_CTL, 32'h0, OK);
      axi_read(A_STS, q, OK);
      check_word(q, d);
      d = 32'h48 | (i % 5);
      axi_write(A_STS, KEY | d, OK);
      d = d | 32'h80;
      base = refs;
      repeat (2) @(posedge clock);
      check_bit(match_irq, 1'b0);
      wait_irq;
      repeat (100) @(posedge clock);
      check_word(refs - base, i < 5 ? burst(i) : 0);
    end
    axi_write(A_STS, KEY | 32'h48, OK);
    repeat (2) @(posedge clock);
    check_bit(match_irq, 1'b1);
    axi_write(A_CTL, 32'h800, OK);
    bus_released <= 1'b1;
    base = refs;
    for (i = 0; i < 2; i = i + 1) begin
      axi_read(A_STS, q, OK);
      axi_write(A_STS, KEY | 32'h48, OK);
      wait_irq;
    end
    repeat (20) @(posedge clock);
    check_bit(refresh_bus_request_out, 1'b1);
    check_word(refs - base, 0);
    bus_released <= 1'b0;
    repeat (50) @(posedge clock);
    check_word(refs - base, 1);
    check_bit(refresh_busy, 1'b0);
    for (i = 0; i < 3; i = i + 1) begin
      axi_write(A_CTL, i == 0 ? 32'hc00 : (i == 1 ? 32'h2800 : 32'h2400), OK);
      repeat (20) @(posedge clock);
      check_bit(refresh_busy, 1'b1);
      check_word({28'h0, last_cmd},
        {28'h0, i == 0 ? `SRPC_CMD_REF : `SRPC_CMD_DPD});
      check_bit(mem_cke, 1'b0);
      axi_write(A_CTL, 32'h0, OK);
      repeat (20) @(posedge clock);
    end
    for (i = 0; i < 2; i = i + 1) begin
      axi_write(A_CTL, i * 32'h200, OK);
      @(posedge clock);
      access_done <= 1'b1;
      @(posedge clock);
      access_done <= 1'b0;
      repeat (5) @(posedge clock);
      check_bit(mem_cke, i == 0);
    end
    complete_run;
  end
endmodule // srpc_refresh_power_test
